//--- verilog/alert_consts.svh
// Offsets, field positions, reset values and mode codes of the alert bank.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef ALERT_CONSTS_SVH
`define ALERT_CONSTS_SVH

// Register offsets on the register access port
`define MASK_ENABLE_ADDR   8'h0F
`define PG_UPPER_ADDR      8'h10

// Reset values
`define MASK_ENABLE_RESET  16'h0002
`define PG_UPPER_RESET     16'h2710

// Mask/enable field positions
`define RSV_BIT            15
// Channel 1 sits in the top bit of each three-bit field
`define SEL_HI             14
`define SEL_LO             12
`define WARN_LATCH_BIT     11
`define CRIT_LATCH_BIT     10
`define CRIT_HI            9
`define CRIT_LO            7
`define SUM_FLAG_BIT       6
`define WARN_HI            5
`define WARN_LO            3
`define PG_FLAG_BIT        2
`define TIMING_FLAG_BIT    1
`define CONV_FLAG_BIT      0

// Limit data field of the upper-limit register, 8 mV per step
`define LIMIT_HI           15
`define LIMIT_LO           3

// Shunt data field, 40 uV per step
`define SHUNT_LO           3

// Operating mode codes that power the converter down, and the bus enable bit
`define MODE_OFF_A         3'h0
`define MODE_OFF_B         3'h4
`define MODE_BUS_BIT       1

`endif

//--- verilog/alert_pkg.sv
// Types shared by the alert bank modules.
// Assumes no other package.
package alert_pkg;

	typedef logic [15:0] word_t;

	typedef enum logic {
		PG_LOW  = 1'b0,
		PG_HIGH = 1'b1
	} pg_state_e;

endpackage

//--- verilog/limit_compare.sv
// Signed window compare of three bus readings against two limits.
// Assumes readings and limits share the 8 mV field in bits 15 to 3.
`timescale 1ns/1ps
`include "alert_consts.svh"

module limit_compare
	import alert_pkg::*;
(
	// Three bus readings, channel 1 in the low word
	input  wire logic [47:0] bus_values,
	// Limits
	input  wire word_t       upper_limit,
	input  wire word_t       lower_limit,
	// Results
	output logic             all_above,
	output logic             any_below
);

	logic [2:0] above;
	logic [2:0] below;

	// Per-channel signed compare on the limit field
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_chan
			logic signed [12:0] val;
			assign val      = bus_values[16*i+15 : 16*i+3];
			assign above[i] = val > $signed(upper_limit[`LIMIT_HI:`LIMIT_LO]);
			assign below[i] = val < $signed(lower_limit[`LIMIT_HI:`LIMIT_LO]);
		end
	endgenerate

	// Combine channels
	assign all_above = &above;
	assign any_below = |below;

endmodule

//--- verilog/alert_mask_power_valid_ctrl.sv
// Alert mask/enable register, alert flags, power-good window and shunt sum.
// Assumes a serial front end that turns bus frames into one-cycle register
// strobes, and a conversion engine that reports results as update pulses.
`timescale 1ns/1ps
`include "alert_consts.svh"

// Behaviour
// - Mask read clears flags; writes keep flags
// - Bits 14-12 select channels summed
// - Sum selection leaves channel measurements alone
// - Bit 11: warning alert transparent or latched
// - Bit 10: critical alert transparent or latched
// - Bits 9-7 critical flags, assert critical alert
// - Bit 6 sum flag, asserts critical alert
// - Bits 5-3 warning flags, assert warning alert
// - Bit 2 mirrors power-good pin, no read clear
// - Bit 1 timing flag, high default, sticky
// - Bit 0 set on conversions done, read clears
// - Configuration write clears bit 0 unless off
// - Mask at 0Fh, reset 0002h, bit 15 reserved
// - All bus channels above upper raises power-good
// - Power-good watched only with bus measurements on
// - Upper limit 16-bit signed, 8 mV, reset 2710h
// - Any bus below lower drops power-good
// - Sum compared after each full channel cycle
module alert_mask_power_valid_ctrl
	import alert_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        soft_reset,
	// Register access port from the serial front end
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr_stb,
	input  wire logic        reg_rd_stb,
	input  wire word_t       reg_wdata,
	output word_t            reg_rdata,
	output logic             reg_rd_valid,
	// Configuration state and writes
	input  wire logic [2:0]  config_mode,
	input  wire logic        config_wr_stb,
	input  wire logic [2:0]  config_wr_mode,
	// Per-channel limit compare results
	input  wire logic [2:0]  crit_update,
	input  wire logic [2:0]  crit_over,
	input  wire logic [2:0]  warn_update,
	input  wire logic [2:0]  warn_over,
	// Shunt readings and sum inputs
	input  wire logic [47:0] shunt_values,
	input  wire logic        cycle_done,
	input  wire word_t       sum_limit,
	output word_t            sum_value,
	// Bus readings for power-good
	input  wire logic [47:0] bus_values,
	input  wire logic        bus_update,
	input  wire word_t       pg_lower_limit,
	// Conversion and timing events
	input  wire logic        conv_done,
	input  wire logic        timing_event,
	// Alert outputs
	output logic             crit_alert_n,
	output logic             warn_alert_n,
	output logic             power_good_pin,
	output logic             timing_ctl_pin
);

	// Stored control fields
	logic        rsv_q;
	logic [2:0]  sum_channel_select_q;
	logic        warn_latch_en_q;
	logic        crit_latch_en_q;
	word_t       pg_upper_q;

	// Flags
	logic [2:0]  crit_flags_q;
	logic        sum_alert_flag_q;
	logic [2:0]  warn_flags_q;
	logic        timing_sticky_flag_q;
	logic        conv_done_flag_q;
	pg_state_e   pg_state_q;

	// Current compare results for transparent mode
	logic [2:0]  crit_cur_q;
	logic        sum_cur_q;
	logic [2:0]  warn_cur_q;

	// Decoded strobes and helpers
	logic        soft_clr;
	logic        mask_wr;
	logic        mask_rd;
	logic        upper_wr;
	logic        mode_off;
	logic        bus_enabled;
	logic        all_above;
	logic        any_below;
	logic        sum_over;
	logic [15:0] sum_d;
	word_t       mask_view;

	// Reset source shared by every clocked process
	assign soft_clr = !resetn || soft_reset;

	// Address decode of the two registers held here
	always_comb begin
		mask_wr  = 1'b0;
		mask_rd  = 1'b0;
		upper_wr = 1'b0;
		if (reg_addr == `MASK_ENABLE_ADDR) begin
			mask_wr = reg_wr_stb;
			mask_rd = reg_rd_stb;
		end else if (reg_addr == `PG_UPPER_ADDR) begin
			upper_wr = reg_wr_stb;
		end
	end

	// Mode decode
	assign mode_off    = (config_wr_mode == `MODE_OFF_A) || (config_wr_mode == `MODE_OFF_B);
	assign bus_enabled = config_mode[`MODE_BUS_BIT];

	// Assembled mask/enable read value
	always_comb begin
		mask_view                   = 16'h0000;
		mask_view[`RSV_BIT]         = rsv_q;
		mask_view[`SEL_HI:`SEL_LO]  = sum_channel_select_q;
		mask_view[`WARN_LATCH_BIT]  = warn_latch_en_q;
		mask_view[`CRIT_LATCH_BIT]  = crit_latch_en_q;
		mask_view[`CRIT_HI:`CRIT_LO] = {crit_flags_q[0], crit_flags_q[1], crit_flags_q[2]};
		mask_view[`SUM_FLAG_BIT]    = sum_alert_flag_q;
		mask_view[`WARN_HI:`WARN_LO] = {warn_flags_q[0], warn_flags_q[1], warn_flags_q[2]};
		mask_view[`PG_FLAG_BIT]     = power_good_pin;
		mask_view[`TIMING_FLAG_BIT] = timing_sticky_flag_q;
		mask_view[`CONV_FLAG_BIT]   = conv_done_flag_q;
	end

	// Control fields; writes never touch the flag bits
	always_ff @(posedge mclk) begin
		if (soft_clr) begin
			rsv_q                <= 1'(`MASK_ENABLE_RESET >> `RSV_BIT);
			sum_channel_select_q <= 3'h0;
			warn_latch_en_q      <= 1'b0;
			crit_latch_en_q      <= 1'b0;
		end else if (mask_wr) begin
			rsv_q                <= reg_wdata[`RSV_BIT];
			sum_channel_select_q <= reg_wdata[`SEL_HI:`SEL_LO];
			warn_latch_en_q      <= reg_wdata[`WARN_LATCH_BIT];
			crit_latch_en_q      <= reg_wdata[`CRIT_LATCH_BIT];
		end
	end

	// Power-good upper limit, all 16 bits stored
	always_ff @(posedge mclk) begin
		if (soft_clr) begin
			pg_upper_q <= `PG_UPPER_RESET;
		end else if (upper_wr) begin
			pg_upper_q <= reg_wdata;
		end
	end

	// Read data; flags are sampled before the read clears them
	always_ff @(posedge mclk) begin
		if (soft_clr) begin
			reg_rdata    <= 16'h0000;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_stb;
			if (reg_rd_stb) begin
				if (reg_addr == `MASK_ENABLE_ADDR) begin
					reg_rdata <= mask_view;
				end else if (reg_addr == `PG_UPPER_ADDR) begin
					reg_rdata <= pg_upper_q;
				end else begin
					reg_rdata <= 16'h0000;
				end
			end
		end
	end

	// Current compare state per channel, refreshed on each update
	always_ff @(posedge mclk) begin
		if (soft_clr) begin
			crit_cur_q <= 3'h0;
			warn_cur_q <= 3'h0;
		end else begin
			crit_cur_q <= (crit_update & crit_over) | (~crit_update & crit_cur_q);
			warn_cur_q <= (warn_update & warn_over) | (~warn_update & warn_cur_q);
		end
	end

	// Critical and warning flags; a new event wins over the read clear
	always_ff @(posedge mclk) begin
		if (soft_clr) begin
			crit_flags_q <= 3'h0;
			warn_flags_q <= 3'h0;
		end else begin
			crit_flags_q <= (crit_flags_q & {3{!mask_rd}}) | (crit_update & crit_over);
			warn_flags_q <= (warn_flags_q & {3{!mask_rd}}) | (warn_update & warn_over);
		end
	end

	// Sum of selected shunt readings; select bit 2 gates channel 1
	always_comb begin
		logic signed [16:0] acc;
		acc = 17'sh0_0000;
		for (int k = 0; k < 3; k++) begin
			if (sum_channel_select_q[2-k]) begin
				acc = acc + 17'(signed'(shunt_values[16*k+15 -: 13]));
			end
		end
		sum_d = {acc[14:0], 1'b0};
	end

	// Sum compare against its limit
	assign sum_over = $signed(sum_d[15:1]) > $signed(sum_limit[15:1]);

	// Sum register and sum flag, refreshed after each full channel cycle
	always_ff @(posedge mclk) begin
		if (soft_clr) begin
			sum_value        <= 16'h0000;
			sum_cur_q        <= 1'b0;
			sum_alert_flag_q <= 1'b0;
		end else begin
			if (cycle_done) begin
				sum_value <= sum_d;
				sum_cur_q <= sum_over;
			end
			sum_alert_flag_q <= (sum_alert_flag_q && !mask_rd) || (cycle_done && sum_over);
		end
	end

	// Conversion-ready flag; completion wins over either clear
	always_ff @(posedge mclk) begin
		if (soft_clr) begin
			conv_done_flag_q <= 1'b0;
		end else if (conv_done) begin
			conv_done_flag_q <= 1'b1;
		end else if (mask_rd) begin
			conv_done_flag_q <= 1'b0;
		end else if (config_wr_stb && !mode_off) begin
			conv_done_flag_q <= 1'b0;
		end
	end

	// Timing flag; reset, soft reset and timing events all set it high, nothing clears it
	always_ff @(posedge mclk) begin
		if (soft_clr) begin
			timing_sticky_flag_q <= 1'b1;
		end else if (timing_event) begin
			timing_sticky_flag_q <= 1'b1;
		end
	end

	// Window compare of the bus readings
	limit_compare u_limit_compare (
		.bus_values  (bus_values),
		.upper_limit (pg_upper_q),
		.lower_limit (pg_lower_limit),
		.all_above   (all_above),
		.any_below   (any_below)
	);

	// Power-good state; register reads have no effect on it
	always_ff @(posedge mclk) begin
		if (soft_clr) begin
			pg_state_q <= PG_LOW;
		end else if (!bus_enabled) begin
			pg_state_q <= PG_LOW;
		end else if (bus_update) begin
			case (pg_state_q)
				PG_LOW: begin
					if (all_above) begin
						pg_state_q <= PG_HIGH;
					end
				end
				PG_HIGH: begin
					if (any_below) begin
						pg_state_q <= PG_LOW;
					end
				end
				default: begin
					pg_state_q <= PG_LOW;
				end
			endcase
		end
	end

	// Output pins, the two alert pins active low; latched mode follows flags, else current state
	always_ff @(posedge mclk) begin
		if (soft_clr) begin
			crit_alert_n   <= 1'b1;
			warn_alert_n   <= 1'b1;
			power_good_pin <= 1'b0;
			timing_ctl_pin <= 1'b1;
		end else begin
			if (crit_latch_en_q) begin
				crit_alert_n <= !(|crit_flags_q || sum_alert_flag_q);
			end else begin
				crit_alert_n <= !(|crit_cur_q || sum_cur_q);
			end
			if (warn_latch_en_q) begin
				warn_alert_n <= !(|warn_flags_q);
			end else begin
				warn_alert_n <= !(|warn_cur_q);
			end
			power_good_pin <= pg_state_q;
			timing_ctl_pin <= timing_sticky_flag_q;
		end
	end

endmodule

//--- testbench/alert_ctrl_props.sv
// Port-level timing checks of the alert bank.
// Assumes it is bound onto alert_mask_power_valid_ctrl.
`timescale 1ns/1ps
module alert_ctrl_props
	import alert_pkg::*;
(
	// Clock and resets
	input wire logic       mclk,
	input wire logic       resetn,
	input wire logic       soft_reset,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic       reg_rd_stb,
	input wire word_t      reg_rdata,
	input wire logic       reg_rd_valid,
	// Events
	input wire logic [2:0] config_mode,
	input wire logic [2:0] crit_update,
	input wire logic [2:0] crit_over,
	input wire logic [2:0] warn_update,
	input wire logic [2:0] warn_over,
	input wire logic       bus_update,
	input wire logic       cycle_done,
	input wire word_t      sum_value,
	// Pins
	input wire logic       crit_alert_n,
	input wire logic       warn_alert_n,
	input wire logic       power_good_pin,
	input wire logic       timing_ctl_pin
);
	// Either reset quiets the checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn || soft_reset);
	// Bus measurements switched off
	sequence bus_off;
		!config_mode[1];
	endsequence
	// Read answer one cycle after its strobe, then only if strobed again
	sequence rd_answer;
		reg_rd_valid ##1 (reg_rd_valid == $past(reg_rd_stb));
	endsequence
	chk_read_answer: assert property (reg_rd_stb |=> rd_answer)
		else $error("read answer missing");
	chk_rdata_hold: assert property ($past(resetn) && !$past(soft_reset) &&
		!$past(reg_rd_stb) |-> $stable(reg_rdata)) else $error("read data moved");
	chk_unmapped_zero: assert property (reg_rd_stb &&
		!(reg_addr inside {8'h0F, 8'h10}) |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	chk_timing_high: assert property (timing_ctl_pin)
		else $error("timing pin low");
	chk_crit_cause: assert property ($fell(crit_alert_n) |->
		$past(|(crit_update & crit_over), 2) || $past(cycle_done, 2))
		else $error("critical alert without cause");
	chk_warn_cause: assert property ($fell(warn_alert_n) |->
		$past(|(warn_update & warn_over), 2)) else $error("warning without cause");
	chk_pg_rise: assert property ($rose(power_good_pin) |->
		$past(bus_update, 2) && $past(config_mode[1], 2))
		else $error("power good rose without cause");
	chk_pg_forced: assert property (bus_off |-> ##2 !power_good_pin)
		else $error("power good high with bus off");
	chk_sum_hold: assert property ($past(resetn) && !$past(soft_reset) &&
		!$past(cycle_done) |-> $stable(sum_value)) else $error("sum moved between cycles");
endmodule

bind alert_mask_power_valid_ctrl alert_ctrl_props chk (.mclk(mclk), .resetn(resetn),
	.soft_reset(soft_reset), .reg_addr(reg_addr), .reg_rd_stb(reg_rd_stb),
	.reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .config_mode(config_mode),
	.crit_update(crit_update), .crit_over(crit_over), .warn_update(warn_update),
	.warn_over(warn_over), .bus_update(bus_update), .cycle_done(cycle_done),
	.sum_value(sum_value), .crit_alert_n(crit_alert_n), .warn_alert_n(warn_alert_n),
	.power_good_pin(power_good_pin), .timing_ctl_pin(timing_ctl_pin));

//--- testbench/reg_host.sv
// Host model issuing one-cycle register strobes.
// Assumes reads are answered one cycle after the strobe edge.
`timescale 1ns/1ps
module reg_host
	import alert_pkg::*;
(
	// Clock
	input  wire logic       mclk,
	// Strobe port
	output logic [7:0]      reg_addr,
	output logic            reg_wr_stb,
	output logic            reg_rd_stb,
	output word_t           reg_wdata,
	input  wire word_t      reg_rdata,
	input  wire logic       reg_rd_valid
);
	// Idle lines at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr_stb = 1'b0;
		reg_rd_stb = 1'b0;
		reg_wdata = 16'h0000;
	end
	// Released lines show the inverse of the last value
	task automatic wr(input logic [7:0] a, input word_t d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_stb <= 1'b1;
		@(posedge mclk);
		reg_wr_stb <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// Data taken at the edge that sees the answer
	task automatic rd(input logic [7:0] a, output word_t d);
		int n;
		@(posedge mclk);
		reg_addr <= a;
		reg_rd_stb <= 1'b1;
		@(posedge mclk);
		reg_rd_stb <= 1'b0;
		reg_addr <= ~a;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (reg_rd_valid !== 1'b1 && n < 4);
		d = reg_rdata;
	endtask
endmodule

//--- testbench/alert_mask_power_valid_ctrl_tb.sv
// Self-checking bench for the alert bank.
// Assumes reg_host as register master and the bank's constants header.
`timescale 1ns/1ps
`include "alert_consts.svh"
module alert_mask_power_valid_ctrl_tb
	import alert_pkg::*;
;
	logic        mclk = 1'b0, resetn = 1'b0, soft_reset = 1'b0;
	logic [7:0]  reg_addr;
	logic        reg_wr_stb, reg_rd_stb, reg_rd_valid;
	word_t       reg_wdata, reg_rdata, sum_value;
	logic [2:0]  config_mode = 3'h7, config_wr_mode = 3'h0;
	logic        config_wr_stb = 1'b0, cycle_done = 1'b0, bus_update = 1'b0;
	logic        conv_done = 1'b0, timing_event = 1'b0;
	logic [2:0]  crit_update = 3'h0, crit_over = 3'h0, warn_update = 3'h0, warn_over = 3'h0;
	logic [47:0] shunt_values = 48'h0000_0000_0000, bus_values = 48'h0000_0000_0000;
	word_t       sum_limit = 16'h7FFE, pg_lower_limit = 16'h0400;
	logic        crit_alert_n, warn_alert_n, power_good_pin, timing_ctl_pin;
	int          n_errors = 0, comparisons = 0, cycles = 0;
	logic [2:0]  modes [4] = '{3'h0, 3'h4, 3'h7, 3'h2};

	// Bank and host
	alert_mask_power_valid_ctrl uut (.mclk(mclk), .resetn(resetn), .soft_reset(soft_reset),
		.reg_addr(reg_addr), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
		.config_mode(config_mode), .config_wr_stb(config_wr_stb),
		.config_wr_mode(config_wr_mode), .crit_update(crit_update), .crit_over(crit_over),
		.warn_update(warn_update), .warn_over(warn_over), .shunt_values(shunt_values),
		.cycle_done(cycle_done), .sum_limit(sum_limit), .sum_value(sum_value),
		.bus_values(bus_values), .bus_update(bus_update), .pg_lower_limit(pg_lower_limit),
		.conv_done(conv_done), .timing_event(timing_event), .crit_alert_n(crit_alert_n),
		.warn_alert_n(warn_alert_n), .power_good_pin(power_good_pin),
		.timing_ctl_pin(timing_ctl_pin));
	reg_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr_stb(reg_wr_stb),
		.reg_rd_stb(reg_rd_stb), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rd_valid(reg_rd_valid));

	// 200 MHz clock
	always #2.5 mclk = ~mclk;
	// Hang guard
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_errors++;
			finish_test();
		end
	end

	task automatic chk(input string nm, input word_t seen, input word_t exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input word_t exp, input string nm);
		word_t d;
		host.rd(a, d);
		chk(nm, d, exp);
	endtask
	// Lets pins settle three edges after an event
	task automatic settle();
		repeat (3) @(posedge mclk);
	endtask
	task automatic ev(input logic [2:0] cu, input logic [2:0] co, input logic [2:0] wu,
		input logic [2:0] wo);
		@(posedge mclk);
		{crit_update, crit_over, warn_update, warn_over} <= {cu, co, wu, wo};
		@(posedge mclk);
		{crit_update, crit_over, warn_update, warn_over} <= 12'h000;
		settle();
	endtask
	// Bits: sum cycle, bus update, conversion, timing, configuration write
	task automatic pulse(input logic [4:0] p);
		@(posedge mclk);
		{cycle_done, bus_update, conv_done, timing_event, config_wr_stb} <= p;
		@(posedge mclk);
		{cycle_done, bus_update, conv_done, timing_event, config_wr_stb} <= 5'h00;
		settle();
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		rchk(`MASK_ENABLE_ADDR, 16'h0002, "mask reset");
		rchk(`PG_UPPER_ADDR, 16'h2710, "upper reset");
		rchk(8'h20, 16'h0000, "unmapped");
		chk("timing pin", timing_ctl_pin, 16'h0001);
		host.wr(`MASK_ENABLE_ADDR, 16'hFFFF);
		rchk(`MASK_ENABLE_ADDR, 16'hFC02, "mask write");
		host.wr(`MASK_ENABLE_ADDR, 16'h0000);
		host.wr(`PG_UPPER_ADDR, 16'h0807);
		rchk(`PG_UPPER_ADDR, 16'h0807, "upper write");
		$display("test registers done");
		ev(3'h2, 3'h2, 3'h4, 3'h4);
		chk("crit low", crit_alert_n, 16'h0000);
		chk("warn low", warn_alert_n, 16'h0000);
		ev(3'h2, 3'h0, 3'h4, 3'h0);
		chk("crit follows", crit_alert_n, 16'h0001);
		chk("warn follows", warn_alert_n, 16'h0001);
		rchk(`MASK_ENABLE_ADDR, 16'h010A, "flags");
		rchk(`MASK_ENABLE_ADDR, 16'h0002, "flags cleared");
		host.wr(`MASK_ENABLE_ADDR, 16'h0C00);
		ev(3'h1, 3'h1, 3'h1, 3'h1);
		ev(3'h1, 3'h0, 3'h1, 3'h0);
		chk("crit held", crit_alert_n, 16'h0000);
		chk("warn held", warn_alert_n, 16'h0000);
		rchk(`MASK_ENABLE_ADDR, 16'h0E22, "latched flags");
		settle();
		chk("crit released", crit_alert_n, 16'h0001);
		chk("warn released", warn_alert_n, 16'h0001);
		$display("test alerts done");
		host.wr(`MASK_ENABLE_ADDR, 16'h5000);
		shunt_values <= {16'h0018, 16'h0100, 16'h0010};
		sum_limit <= 16'h0008;
		pulse(5'h10);
		chk("sum", sum_value, 16'h000A);
		chk("sum crit", crit_alert_n, 16'h0000);
		rchk(`MASK_ENABLE_ADDR, 16'h5042, "sum flag");
		sum_limit <= 16'h000A;
		pulse(5'h10);
		rchk(`MASK_ENABLE_ADDR, 16'h5002, "sum at limit");
		$display("test sum done");
		pulse(5'h04);
		rchk(`MASK_ENABLE_ADDR, 16'h5003, "conv set");
		rchk(`MASK_ENABLE_ADDR, 16'h5002, "conv cleared");
		foreach (modes[i]) begin
			pulse(5'h04);
			config_wr_mode <= modes[i];
			pulse(5'h01);
			rchk(`MASK_ENABLE_ADDR, (i < 2) ? 16'h5003 : 16'h5002, "conv cfg");
		end
		$display("test conversion done");
		bus_values <= {3{16'h0900}};
		pulse(5'h08);
		chk("pg high", power_good_pin, 16'h0001);
		rchk(`MASK_ENABLE_ADDR, 16'h5006, "pg flag");
		rchk(`MASK_ENABLE_ADDR, 16'h5006, "pg flag kept");
		bus_values <= {16'h0900, 16'h0300, 16'h0900};
		pulse(5'h08);
		chk("pg drop", power_good_pin, 16'h0000);
		rchk(`MASK_ENABLE_ADDR, 16'h5002, "pg flag off");
		bus_values <= {3{16'h0900}};
		pulse(5'h08);
		config_mode <= 3'h4;
		pulse(5'h08);
		chk("pg bus off", power_good_pin, 16'h0000);
		$display("test power good done");
		pulse(5'h02);
		chk("timing kept", timing_ctl_pin, 16'h0001);
		soft_reset <= 1'b1;
		@(posedge mclk);
		soft_reset <= 1'b0;
		rchk(`MASK_ENABLE_ADDR, 16'h0002, "soft reset");
		rchk(`PG_UPPER_ADDR, 16'h2710, "soft upper");
		$display("test soft reset done");
		finish_test();
	end
endmodule
